// ---- srnx_pkg.sv ----
// Purpose: Constants shared by the stack, call, return and negate execution unit
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Byte offsets, field positions, reset values and opcodes live here
package srnx_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_WORK = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_BANK = 8'h10;
	localparam logic [7:0] OFS_PROD = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_STACK = 8'h1c;
	localparam logic [7:0] OFS_SHADOW = 8'h20;
	localparam logic [7:0] OFS_INTEN = 8'h24;
	localparam logic [7:0] OFS_INDEX = 8'h28;
	localparam logic [7:0] OFS_LATCH = 8'h2c;
	localparam logic [7:0] OFS_MADDR = 8'h30;
	localparam logic [7:0] OFS_MDATA = 8'h34;
	// ==========================================================
	// Flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;
	// Control and status bit positions
	localparam int CTRL_EXT = 0;
	localparam int STAT_BUSY = 8;
	localparam int STAT_UNSUP = 9;
	localparam int STAT_SRST = 10;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_WORK = 8'h00;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [15:0] RST_PROD = 16'h0000;
	localparam logic [20:0] RST_PC = 21'h000000;
	localparam logic [11:0] RST_INDEX = 12'h000;
	// ==========================================================
	// Opcodes and address map constants
	localparam logic [15:0] OP_POP = 16'h0006;
	localparam logic [15:0] OP_PUSH = 16'h0005;
	localparam logic [15:0] OP_SRESET = 16'h00ff;
	localparam logic [15:0] OP_NOP = 16'h0000;
	localparam logic [14:0] OP_IRET = 15'h0008;
	localparam logic [7:0] OP_RETLIT = 8'h0c;
	localparam logic [6:0] OP_MULREG = 7'h01;
	localparam logic [6:0] OP_NEG = 7'h36;
	localparam logic [4:0] OP_REL_CALL = 5'h1b;
	localparam logic [3:0] OP_NOP_HI = 4'hf;
	localparam logic [7:0] ACC_LIMIT = 8'h5f;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- srnx_core.sv ----
// Purpose: Executes multiply, negate, no-op, stack, call and return instructions
// Assumes: Instruction cycle of four clocks, instructions issued over AXI4-Lite
// Notes: Data memory and return stack are arrays outside the state struct
// Functional notes
// RULE1 - Register multiply puts the unsigned product of W and the file byte into product_high:low, nothing else.
// RULE2 - Negate replaces the file byte with its two's complement and updates N, OV, C, DC and Z.
// RULE3 - Access bit 0 selects the access bank, access bit 1 uses the bank select register.
// RULE4 - With access bit 0 and extended set enabled, offsets up to 5Fh are indexed from the index base.
// RULE5 - Pop drops the stack top in one cycle so the previous entry becomes the top.
// RULE6 - Push puts PC plus 2 on the stack in one cycle, the old top moving down.
// RULE7 - Relative call pushes PC plus 2 and jumps to PC plus 2 plus twice the signed offset.
// RULE8 - Relative call takes two cycles, the second doing nothing.
// RULE9 - Software reset returns every core register and flag to its reset value.
// RULE10 - Interrupt return pops the stack into PC, sets a global enable and takes two cycles.
// RULE11 - Interrupt return with s set restores W, flags and bank from shadows, else leaves them.
// RULE12 - Both return instructions leave the PC latch registers unchanged.
// RULE13 - Return with literal loads W with the literal and pops the return address over two cycles.
// RULE14 - An all-zero word or a word with upper nibble all ones is a one-cycle no-op.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module srnx_core #(
	parameter int STACK_DEPTH = 31,
	parameter int MEM_DEPTH = 4096
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] q;
		logic pend;
		logic cyc2;
		logic [15:0] instr;
		logic [7:0] work;
		logic [4:0] flags;
		logic [3:0] bank;
		logic [15:0] prod;
		logic [20:0] pc;
		logic [4:0] sp;
		logic [7:0] working_shadow;
		logic [4:0] flags_shadow;
		logic [3:0] bank_shadow;
		logic global_int_en_high;
		logic global_int_en_low;
		logic ext_en;
		logic [11:0] index;
		logic [7:0] pc_latch_high;
		logic [4:0] pc_latch_upper;
		logic [11:0] maddr;
		logic unsup;
		logic srst_seen;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} srnx_state_t;

	srnx_state_t st_reg;
	srnx_state_t st_next;
	logic [7:0] mem [MEM_DEPTH];
	logic [20:0] stack [STACK_DEPTH + 1];
	logic mem_we;
	logic [11:0] mem_wa;
	logic [7:0] mem_wd;
	logic stk_we;
	logic [4:0] stk_wa;
	logic [20:0] stk_wd;

	// ==========================================================
	// Helpers
	// Byte-lane merge of a write into a register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Effective data address of a file-register operand
	function automatic logic [11:0] eff_addr(input logic acc, input logic [7:0] f,
		input logic [3:0] bank, input logic ext, input logic [11:0] idx);
		logic [11:0] r;
		r = {bank, f}; // see RULE3
		if (!acc) begin
			if (ext && f <= srnx_pkg::ACC_LIMIT) begin
				r = idx + {4'h0, f}; // see RULE4
			end else if (f <= srnx_pkg::ACC_LIMIT) begin
				r = {4'h0, f}; // see RULE3
			end else begin
				r = {srnx_pkg::ACC_HI_BANK, f}; // see RULE3
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic [11:0] ea;
		logic [7:0] opnd;
		logic [7:0] neg;
		logic [20:0] pc2;
		logic [20:0] top;
		logic [31:0] rd;
		logic [31:0] cur;
		logic exec;
		logic busy;
		logic [1:0] resp;
		st_next = st_reg;
		mem_we = 1'b0;
		mem_wa = st_reg.maddr;
		mem_wd = 8'h00;
		stk_we = 1'b0;
		stk_wa = st_reg.sp;
		stk_wd = 21'h000000;
		ea = eff_addr(st_reg.instr[8], st_reg.instr[7:0], st_reg.bank, st_reg.ext_en,
			st_reg.index);
		opnd = mem[ea];
		neg = 8'h00 - opnd;
		pc2 = st_reg.pc + 21'h000002;
		top = (st_reg.sp == 5'h00) ? 21'h000000 : stack[st_reg.sp];
		exec = st_reg.pend && (st_reg.q == srnx_pkg::Q_LAST);
		busy = st_reg.pend || st_reg.cyc2;
		rd = 32'h00000000;
		cur = 32'h00000000;
		resp = srnx_pkg::RESP_OKAY;

		// Instruction cycle phase divider
		st_next.q = st_reg.q + 2'h1;

		// Second cycle of two-cycle instructions does nothing
		if (st_reg.cyc2 && st_reg.q == srnx_pkg::Q_LAST) begin
			st_next.cyc2 = 1'b0; // see RULE8
		end

		// ------------------------------------------------------
		// Execute at the last phase of the instruction cycle
		if (exec) begin
			st_next.pend = 1'b0;
			st_next.pc = pc2;
			if (st_reg.instr == srnx_pkg::OP_NOP || st_reg.instr[15:12] == srnx_pkg::OP_NOP_HI)
				begin
				st_next.pc = pc2; // see RULE14
			end else if (st_reg.instr[15:9] == srnx_pkg::OP_MULREG) begin
				st_next.prod = {8'h00, st_reg.work} * {8'h00, opnd}; // see RULE1
			end else if (st_reg.instr[15:9] == srnx_pkg::OP_NEG) begin
				mem_we = 1'b1; // see RULE2
				mem_wa = ea;
				mem_wd = neg;
				st_next.flags[srnx_pkg::FLAG_C] = (opnd == 8'h00);
				st_next.flags[srnx_pkg::FLAG_DC] = (opnd[3:0] == 4'h0);
				st_next.flags[srnx_pkg::FLAG_Z] = (neg == 8'h00);
				st_next.flags[srnx_pkg::FLAG_OV] = (opnd == 8'h80);
				st_next.flags[srnx_pkg::FLAG_N] = neg[7];
			end else if (st_reg.instr == srnx_pkg::OP_POP) begin
				if (st_reg.sp != 5'h00) begin
					st_next.sp = st_reg.sp - 5'h01; // see RULE5
				end
			end else if (st_reg.instr == srnx_pkg::OP_PUSH) begin
				if (st_reg.sp != 5'(STACK_DEPTH)) begin
					st_next.sp = st_reg.sp + 5'h01; // see RULE6
					stk_we = 1'b1;
					stk_wa = st_reg.sp + 5'h01;
					stk_wd = pc2;
				end
			end else if (st_reg.instr[15:11] == srnx_pkg::OP_REL_CALL) begin
				if (st_reg.sp != 5'(STACK_DEPTH)) begin
					st_next.sp = st_reg.sp + 5'h01; // see RULE7
					stk_we = 1'b1;
					stk_wa = st_reg.sp + 5'h01;
					stk_wd = pc2;
				end
				st_next.pc = pc2 + {{9{st_reg.instr[10]}}, st_reg.instr[10:0], 1'b0}; // see RULE7
				st_next.cyc2 = 1'b1; // see RULE8
			end else if (st_reg.instr == srnx_pkg::OP_SRESET) begin
				st_next.work = srnx_pkg::RST_WORK; // see RULE9
				st_next.flags = srnx_pkg::RST_FLAGS;
				st_next.bank = srnx_pkg::RST_BANK;
				st_next.prod = srnx_pkg::RST_PROD;
				st_next.pc = srnx_pkg::RST_PC;
				st_next.sp = 5'h00;
				st_next.working_shadow = srnx_pkg::RST_WORK;
				st_next.flags_shadow = srnx_pkg::RST_FLAGS;
				st_next.bank_shadow = srnx_pkg::RST_BANK;
				st_next.global_int_en_high = 1'b0;
				st_next.global_int_en_low = 1'b0;
				st_next.ext_en = 1'b0;
				st_next.index = srnx_pkg::RST_INDEX;
				st_next.pc_latch_high = 8'h00;
				st_next.pc_latch_upper = 5'h00;
				st_next.unsup = 1'b0;
				st_next.srst_seen = 1'b1;
			end else if (st_reg.instr[15:1] == srnx_pkg::OP_IRET) begin
				st_next.pc = top; // see RULE10
				st_next.sp = (st_reg.sp == 5'h00) ? 5'h00 : st_reg.sp - 5'h01;
				if (!st_reg.global_int_en_high) begin
					st_next.global_int_en_high = 1'b1; // see RULE10
				end else begin
					st_next.global_int_en_low = 1'b1;
				end
				if (st_reg.instr[0]) begin
					st_next.work = st_reg.working_shadow; // see RULE11
					st_next.flags = st_reg.flags_shadow;
					st_next.bank = st_reg.bank_shadow;
				end
				st_next.cyc2 = 1'b1; // see RULE10
			end else if (st_reg.instr[15:8] == srnx_pkg::OP_RETLIT) begin
				st_next.work = st_reg.instr[7:0]; // see RULE13
				st_next.pc = top; // see RULE12
				st_next.sp = (st_reg.sp == 5'h00) ? 5'h00 : st_reg.sp - 5'h01;
				st_next.cyc2 = 1'b1; // see RULE13
			end else begin
				st_next.unsup = 1'b1;
			end
		end

		// ------------------------------------------------------
		// Write address and data channels, taken in either order
		if (st_reg.awready && s_axi_awvalid) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr = s_axi_awaddr;
			st_next.awready = 1'b0;
		end
		if (st_reg.wready && s_axi_wvalid) begin
			st_next.w_have = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
			st_next.wready = 1'b0;
		end

		// Register write, held off during the execute phase
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid && !exec) begin
			if (st_reg.awaddr == srnx_pkg::OFS_INSTR) begin
				if (busy) begin
					resp = srnx_pkg::RESP_SLVERR;
				end else begin
					cur = merge({16'h0000, st_reg.instr}, st_reg.wdata, st_reg.wstrb);
					st_next.instr = cur[15:0];
					st_next.pend = 1'b1;
				end
			end else if (st_reg.awaddr == srnx_pkg::OFS_CTRL) begin
				cur = merge({31'h0, st_reg.ext_en}, st_reg.wdata, st_reg.wstrb);
				st_next.ext_en = cur[srnx_pkg::CTRL_EXT];
				if (st_reg.wstrb[1] && st_reg.wdata[srnx_pkg::STAT_UNSUP]) begin
					st_next.unsup = 1'b0;
				end
				if (st_reg.wstrb[1] && st_reg.wdata[srnx_pkg::STAT_SRST]) begin
					st_next.srst_seen = 1'b0;
				end
			end else if (st_reg.awaddr == srnx_pkg::OFS_WORK) begin
				cur = merge({24'h0, st_reg.work}, st_reg.wdata, st_reg.wstrb);
				st_next.work = cur[7:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_FLAGS) begin
				cur = merge({27'h0, st_reg.flags}, st_reg.wdata, st_reg.wstrb);
				st_next.flags = cur[4:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_BANK) begin
				cur = merge({28'h0, st_reg.bank}, st_reg.wdata, st_reg.wstrb);
				st_next.bank = cur[3:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_PROD) begin
				cur = merge({16'h0, st_reg.prod}, st_reg.wdata, st_reg.wstrb);
				st_next.prod = cur[15:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_PC) begin
				cur = merge({11'h0, st_reg.pc}, st_reg.wdata, st_reg.wstrb);
				st_next.pc = {cur[20:1], 1'b0};
			end else if (st_reg.awaddr == srnx_pkg::OFS_SHADOW) begin
				cur = merge({15'h0, st_reg.bank_shadow, st_reg.flags_shadow, st_reg.working_shadow},
					st_reg.wdata, st_reg.wstrb);
				st_next.working_shadow = cur[7:0];
				st_next.flags_shadow = cur[12:8];
				st_next.bank_shadow = cur[16:13];
			end else if (st_reg.awaddr == srnx_pkg::OFS_INTEN) begin
				cur = merge({30'h0, st_reg.global_int_en_low, st_reg.global_int_en_high},
					st_reg.wdata, st_reg.wstrb);
				st_next.global_int_en_high = cur[0];
				st_next.global_int_en_low = cur[1];
			end else if (st_reg.awaddr == srnx_pkg::OFS_INDEX) begin
				cur = merge({20'h0, st_reg.index}, st_reg.wdata, st_reg.wstrb);
				st_next.index = cur[11:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_LATCH) begin
				cur = merge({19'h0, st_reg.pc_latch_upper, st_reg.pc_latch_high}, st_reg.wdata,
					st_reg.wstrb);
				st_next.pc_latch_high = cur[7:0];
				st_next.pc_latch_upper = cur[12:8];
			end else if (st_reg.awaddr == srnx_pkg::OFS_MADDR) begin
				cur = merge({20'h0, st_reg.maddr}, st_reg.wdata, st_reg.wstrb);
				st_next.maddr = cur[11:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_MDATA) begin
				mem_we = st_reg.wstrb[0];
				mem_wa = st_reg.maddr;
				mem_wd = st_reg.wdata[7:0];
			end else if (st_reg.awaddr == srnx_pkg::OFS_STACK) begin
				resp = srnx_pkg::RESP_OKAY;
			end else begin
				resp = srnx_pkg::RESP_SLVERR;
			end
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = resp;
		end

		// Write response handshake reopens the address and data channels
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
		end

		// ------------------------------------------------------
		// Read channel, answered one cycle after the address
		if (st_reg.arready && s_axi_arvalid) begin
			resp = srnx_pkg::RESP_OKAY;
			if (s_axi_araddr == srnx_pkg::OFS_INSTR) begin
				rd = {16'h0000, st_reg.instr};
			end else if (s_axi_araddr == srnx_pkg::OFS_CTRL) begin
				rd = {21'h0, st_reg.srst_seen, st_reg.unsup, busy, 7'h0, st_reg.ext_en};
			end else if (s_axi_araddr == srnx_pkg::OFS_WORK) begin
				rd = {24'h0, st_reg.work};
			end else if (s_axi_araddr == srnx_pkg::OFS_FLAGS) begin
				rd = {27'h0, st_reg.flags};
			end else if (s_axi_araddr == srnx_pkg::OFS_BANK) begin
				rd = {28'h0, st_reg.bank};
			end else if (s_axi_araddr == srnx_pkg::OFS_PROD) begin
				rd = {16'h0, st_reg.prod};
			end else if (s_axi_araddr == srnx_pkg::OFS_PC) begin
				rd = {11'h0, st_reg.pc};
			end else if (s_axi_araddr == srnx_pkg::OFS_STACK) begin
				rd = {6'h0, st_reg.sp, top};
			end else if (s_axi_araddr == srnx_pkg::OFS_SHADOW) begin
				rd = {15'h0, st_reg.bank_shadow, st_reg.flags_shadow, st_reg.working_shadow};
			end else if (s_axi_araddr == srnx_pkg::OFS_INTEN) begin
				rd = {30'h0, st_reg.global_int_en_low, st_reg.global_int_en_high};
			end else if (s_axi_araddr == srnx_pkg::OFS_INDEX) begin
				rd = {20'h0, st_reg.index};
			end else if (s_axi_araddr == srnx_pkg::OFS_LATCH) begin
				rd = {19'h0, st_reg.pc_latch_upper, st_reg.pc_latch_high};
			end else if (s_axi_araddr == srnx_pkg::OFS_MADDR) begin
				rd = {20'h0, st_reg.maddr};
			end else if (s_axi_araddr == srnx_pkg::OFS_MDATA) begin
				rd = {24'h0, mem[st_reg.maddr]};
			end else begin
				resp = srnx_pkg::RESP_SLVERR;
			end
			st_next.rdata = rd;
			st_next.rresp = resp;
			st_next.rvalid = 1'b1;
			st_next.arready = 1'b0;
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
	end

	// ==========================================================
	// State register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
			st_reg.pc <= srnx_pkg::RST_PC;
		end else begin
			st_reg <= st_next;
		end
	end

	// Data memory and return stack arrays
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		if (stk_we) begin
			stack[stk_wa] <= stk_wd;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rdata = st_reg.rdata;
endmodule

// ---- srnx_checker.sv ----
// Purpose: Bus contract assertions for the execution unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to srnx_core below the module
`timescale 1ns/1ns
module srnx_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================================
	// Handshake properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response changed before taken");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after address");
	write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[2:3] s_axi_bvalid)
		else $error("write answer late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open during response");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open during response");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channels not reopened");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened");
	reset_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid)
		else $error("bus not idle after reset");
	resp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
		else $error("bad read response code");
	// Main scenarios
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == srnx_pkg::RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == srnx_pkg::RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == srnx_pkg::RESP_OKAY);
endmodule
bind srnx_core srnx_checker chk (.*);

// ---- stack_call_return_negate_exec_tb.sv ----
// Purpose: Self-checking bench for the execution unit
// Assumes: Register bus driven at rising edges, expectations queued
// Notes: A monitor process compares every read and write response
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module stack_call_return_negate_exec_tb;
	typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} srnx_exp_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, last_rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	srnx_exp_t exp_q[$];
	logic [1:0] resp_q[$];
	int errors = 0;
	int checked = 0;
	int seed = 32'h34eb5294;
	srnx_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	// ==========================================================
	// Clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ==========================================================
	// Verdict and bus tasks
	task summarize;
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Write with both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = srnx_pkg::RESP_OKAY);
		bit done;
		int dly;
		done = 0;
		dly = 2 * ($random(seed) & 1);
		resp_q.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (dly == 0);
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) done = 1;
			else if (i >= dly) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		if (!done) begin
			errors++;
			summarize();
		end
	endtask
	// Read, noting the expected data under a mask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
		input logic [1:0] r = srnx_pkg::RESP_OKAY);
		bit done;
		int dly;
		done = 0;
		dly = 2 * ($random(seed) & 1);
		exp_q.push_back('{e, m, r});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (dly == 0);
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				done = 1;
				last_rd = s_axi_rdata;
			end else if (i >= dly) begin
				s_axi_rready <= 1'b1;
			end
		end
		s_axi_rready <= 1'b0;
		if (!done) begin
			errors++;
			summarize();
		end
	endtask
	// Issue one instruction and wait until not busy
	task automatic ex(input logic [15:0] op, input logic [1:0] r = srnx_pkg::RESP_OKAY);
		wr(srnx_pkg::OFS_INSTR, {16'h0000, op}, r);
		for (int i = 0; i < 20; i++) begin
			rd(srnx_pkg::OFS_CTRL, 32'h0, 32'h0);
			if (last_rd[srnx_pkg::STAT_BUSY] === 1'b0) return;
		end
		errors++;
		summarize();
	endtask
	// Expected negate flags {N, OV, Z, DC, C}
	function automatic logic [4:0] negate_reg(input logic [7:0] f);
		logic [7:0] r;
		r = ~f + 8'h01;
		return {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
	endfunction
	// ==========================================================
	// Monitor: oldest note against each response
	always @(posedge aclk) begin
		srnx_exp_t x;
		logic [1:0] br;
		if (s_axi_rvalid && s_axi_rready) begin
			x = exp_q.pop_front();
			`CHK(s_axi_rresp, x.r)
			if (x.m != 32'h0) `CHK(s_axi_rdata & x.m, x.e & x.m)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			br = resp_q.pop_front();
			`CHK(s_axi_bresp, br)
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] w, f, r;
		logic [7:0] nv[4];
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		nv = '{8'h3a, 8'h00, 8'h80, 8'h00};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(srnx_pkg::OFS_PC, 32'h0);
		rd(srnx_pkg::OFS_STACK, 32'h0);
		// Multiply through bank 1, flags preset
		wr(srnx_pkg::OFS_FLAGS, 32'h15);
		wr(srnx_pkg::OFS_BANK, 32'h1);
		wr(srnx_pkg::OFS_MADDR, 32'h1a5);
		for (int i = 0; i < 3; i++) begin
			w = 8'($random(seed));
			f = 8'($random(seed));
			wr(srnx_pkg::OFS_WORK, {24'h0, w});
			wr(srnx_pkg::OFS_MDATA, {24'h0, f});
			ex(16'h03a5);
			rd(srnx_pkg::OFS_PROD, 32'(w) * 32'(f));
			rd(srnx_pkg::OFS_WORK, {24'h0, w});
			rd(srnx_pkg::OFS_MDATA, {24'h0, f});
			rd(srnx_pkg::OFS_FLAGS, 32'h15);
		end
		// Negate in the low access bank
		nv[3] = 8'($random(seed));
		wr(srnx_pkg::OFS_MADDR, 32'h020);
		for (int i = 0; i < 4; i++) begin
			r = ~nv[i] + 8'h01;
			wr(srnx_pkg::OFS_MDATA, {24'h0, nv[i]});
			ex(16'h6c20);
			rd(srnx_pkg::OFS_MDATA, {24'h0, r});
			rd(srnx_pkg::OFS_FLAGS, {27'h0, negate_reg(nv[i])});
		end
		// Upper access bank, then indexed mode
		wr(srnx_pkg::OFS_MADDR, 32'hf60);
		wr(srnx_pkg::OFS_MDATA, 32'h01);
		ex(16'h6c60);
		rd(srnx_pkg::OFS_MDATA, 32'hff);
		wr(srnx_pkg::OFS_CTRL, 32'h1);
		wr(srnx_pkg::OFS_INDEX, 32'h300);
		wr(srnx_pkg::OFS_MADDR, 32'h305);
		wr(srnx_pkg::OFS_MDATA, 32'h02);
		ex(16'h6c05);
		rd(srnx_pkg::OFS_MDATA, 32'hfe);
		wr(srnx_pkg::OFS_CTRL, 32'h0);
		// Stack, calls and returns
		wr(srnx_pkg::OFS_LATCH, 32'h1234);
		wr(srnx_pkg::OFS_SHADOW, 32'h6a77);
		wr(srnx_pkg::OFS_PC, 32'h1000);
		ex(srnx_pkg::OP_PUSH);
		ex(srnx_pkg::OP_PUSH);
		rd(srnx_pkg::OFS_STACK, {6'h0, 5'h2, 21'h001004});
		ex(srnx_pkg::OP_POP);
		rd(srnx_pkg::OFS_STACK, {6'h0, 5'h1, 21'h001002});
		ex(16'hdc00);
		rd(srnx_pkg::OFS_PC, 32'h0808);
		ex(16'hdbff);
		rd(srnx_pkg::OFS_PC, 32'h1008);
		rd(srnx_pkg::OFS_STACK, {6'h0, 5'h3, 21'h00080a});
		ex(16'h0c5a);
		rd(srnx_pkg::OFS_WORK, 32'h5a);
		rd(srnx_pkg::OFS_PC, 32'h080a);
		ex(16'h0010);
		rd(srnx_pkg::OFS_PC, 32'h1008);
		rd(srnx_pkg::OFS_INTEN, 32'h1);
		rd(srnx_pkg::OFS_WORK, 32'h5a);
		ex(16'h0011);
		rd(srnx_pkg::OFS_PC, 32'h1002);
		rd(srnx_pkg::OFS_INTEN, 32'h3);
		rd(srnx_pkg::OFS_WORK, 32'h77);
		rd(srnx_pkg::OFS_FLAGS, 32'h0a);
		rd(srnx_pkg::OFS_BANK, 32'h3);
		rd(srnx_pkg::OFS_LATCH, 32'h1234);
		// No-op encodings
		ex(16'h0000);
		ex(16'hf123);
		rd(srnx_pkg::OFS_PC, 32'h1006);
		rd(srnx_pkg::OFS_WORK, 32'h77);
		rd(srnx_pkg::OFS_STACK, 32'h0);
		// Unmapped place
		wr(8'h3c, 32'h1, srnx_pkg::RESP_SLVERR);
		rd(8'h3c, 32'h0, 32'hffffffff, srnx_pkg::RESP_SLVERR);
		// Busy refusal during a call, byte strobes, unknown opcode
		wr(srnx_pkg::OFS_INSTR, 32'hd800);
		ex(16'h0000, srnx_pkg::RESP_SLVERR);
		rd(srnx_pkg::OFS_INSTR, 32'hd800);
		s_axi_wstrb <= 4'h1;
		wr(srnx_pkg::OFS_INDEX, 32'hfff);
		s_axi_wstrb <= 4'hf;
		rd(srnx_pkg::OFS_INDEX, 32'h3ff);
		ex(16'h0e00);
		rd(srnx_pkg::OFS_CTRL, 32'h200, 32'h200);
		// Software reset
		ex(srnx_pkg::OP_SRESET);
		rd(srnx_pkg::OFS_WORK, 32'h0);
		rd(srnx_pkg::OFS_PC, 32'h0);
		rd(srnx_pkg::OFS_INTEN, 32'h0);
		rd(srnx_pkg::OFS_LATCH, 32'h0);
		rd(srnx_pkg::OFS_INDEX, 32'h0);
		rd(srnx_pkg::OFS_CTRL, 32'h400, 32'h600);
		summarize();
	end
endmodule
